// ==== erase_suspend_pkg.sv ====
// shared constants for the erase-check and suspend command controller
package erase_suspend_pkg;
   // ==========================================================
   // command opcodes
   localparam logic [7:0] OPC_ERASE_CHECK     = 8'hD0;
   localparam logic [7:0] OPC_HALT_A          = 8'h85;
   localparam logic [7:0] OPC_HALT_B          = 8'h75;
   localparam logic [7:0] OPC_HALT_C          = 8'hB0;
   localparam logic [7:0] OPC_CONTINUE_A      = 8'h7A;
   localparam logic [7:0] OPC_CONTINUE_B      = 8'h8A;
   localparam logic [7:0] OPC_PAGE_PROG       = 8'h02;
   localparam logic [7:0] OPC_PAGE_PROG_WIDE  = 8'h12;
   localparam logic [7:0] OPC_FETCH           = 8'h03;
   localparam logic [7:0] OPC_FETCH_WIDE      = 8'h13;
   localparam logic [7:0] OPC_FAST_FETCH      = 8'h0B;
   localparam logic [7:0] OPC_FAST_FETCH_WIDE = 8'h0C;
   localparam logic [7:0] OPC_DUAL_FETCH      = 8'hBB;
   localparam logic [7:0] OPC_DUAL_FETCH_WIDE = 8'hBC;
   localparam logic [7:0] OPC_QUAD_FETCH      = 8'hEB;
   localparam logic [7:0] OPC_QUAD_FETCH_WIDE = 8'hEC;
   localparam logic [7:0] OPC_QUAD_DDR_FETCH  = 8'hED;
   localparam logic [7:0] OPC_STATUS1_FETCH   = 8'h05;
   localparam logic [7:0] OPC_ANY_REG_FETCH   = 8'h65;
   localparam logic [7:0] OPC_STATUS2_FETCH   = 8'h07;
   localparam logic [7:0] OPC_WRITE_PERMIT    = 8'h06;
   localparam logic [7:0] OPC_CLEAR_OPT       = 8'h30;
   localparam logic [7:0] OPC_CLEAR           = 8'h82;
   localparam logic [7:0] OPC_RESET_ARM       = 8'h66;
   localparam logic [7:0] OPC_RESET           = 8'h99;
   localparam logic [7:0] OPC_SECTOR_ERASE    = 8'hD8;
   localparam logic [7:0] OPC_SECTOR_ERASE_W  = 8'hDC;
   localparam logic [7:0] OPC_SMALL_ERASE     = 8'h20;
   localparam logic [7:0] OPC_SMALL_ERASE_W   = 8'h21;
   localparam logic [7:0] OPC_BULK_ERASE      = 8'h60;
   localparam logic [7:0] OPC_BULK_ERASE_ALT  = 8'hC7;
   localparam logic [7:0] OPC_LOCK_READ       = 8'hFA;
   localparam logic [7:0] OPC_LOCK_WRITE      = 8'hFB;
   localparam logic [7:0] OPC_LOCK_READ_W     = 8'hE0;
   localparam logic [7:0] OPC_LOCK_WRITE_W    = 8'hE1;
   localparam logic [7:0] OPC_PERSIST_READ    = 8'hFC;
   localparam logic [7:0] OPC_PERSIST_READ_W  = 8'hE2;
   // ==========================================================
   // register map (byte offsets) and fields
   localparam logic [3:0] REG_CTRL         = 4'h0;
   localparam logic [3:0] REG_STATUS       = 4'h4;
   localparam logic [3:0] REG_LAST_CMD     = 4'h8;
   localparam logic [3:0] REG_ERASE_SECTOR = 4'hC;
   localparam int CTRL_QUAD_BIT  = 0;
   localparam int CTRL_ADDR4_BIT = 1;
   localparam int CTRL_CLR30_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam int ST1_BUSY_BIT   = 0;
   localparam int ST1_PERMIT_BIT = 1;
   localparam int ST1_PERR_BIT   = 6;
   localparam int ST2_PHALT_BIT  = 0;
   localparam int ST2_EHALT_BIT  = 1;
   localparam int ST2_EOK_BIT    = 2;
   localparam int ST2_LSB        = 8;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS      = 10;
   localparam int ERASE_CHECK_TIME_NS = 20000;
   localparam int SUSPEND_LATENCY_NS  = 40000;
   localparam int OP_TIME_NS          = 500000;
   localparam int ERASE_CHECK_CYCLES = (ERASE_CHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SUSPEND_CYCLES     = SUSPEND_LATENCY_NS / CLK_PERIOD_NS;
   localparam int OP_CYCLES          = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W              = 24;

   typedef enum logic [2:0] {
      OP_IDLE    = 3'b000,
      OP_PROGRAM = 3'b001,
      OP_SECTOR  = 3'b010,
      OP_BULK    = 3'b011,
      OP_CHECK   = 3'b100,
      OP_HALTING = 3'b101
   } op_state_t;
endpackage

// ==== erase_suspend_ctrl.sv ====
// erase-check and program/erase suspend command controller
// Functional notes
// - erase check sets erase-ok bit to sector blank result.
// - erase check takes three or four address bytes per address-length bit.
// - busy stays high through the check, clears when result updated.
// - check needs no write permit; device sets then clears the latch.
// - four-wire mode moves the opcode on four lines, two clocks a byte.
// - three opcodes all mean suspend.
// - suspend only acts on program or sector erase, never bulk erase.
// - busy clears within suspend latency; host polls busy.
// - program-halted bit set when a program is suspended.
// - erase-halted bit set when an erase is suspended.
// - erase suspend allows reads and programs; program suspend reads only.
// - erase suspend allows reading and writing sector lock array.
// - new erase commands ignored while anything is suspended.
// - page program accepted in erase suspend only without halted program.
// - program into the halted erase sector fails and sets program error.
// - all nine array read opcodes accepted during any suspend.
// - all three status reads accepted during any suspend.
// - write permit accepted in erase suspend, not program suspend.
// - clear status: one opcode always, other when option bit selects it; during a suspend the code accepts either only in erase suspend.
// - continue opcodes accepted during suspend and restart the operation.
// - reset arm and reset accepted at any time.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module erase_suspend_ctrl
   import erase_suspend_pkg::*;
#(
   parameter int CHECK_CYC  = ERASE_CHECK_CYCLES,
   parameter int HALT_CYC   = SUSPEND_CYCLES,
   parameter int OP_CYC     = OP_CYCLES,
   parameter int SECTOR_W   = 16
) (
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_NRST,
   input  wire logic [3:0]  I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   input  wire logic [3:0]  I_AVS_BYTEENABLE,
   output var  logic [31:0] O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   input  wire logic        I_SPI_SCK,
   input  wire logic        I_SPI_CS_N,
   input  wire logic [3:0]  I_SPI_IO,
   input  wire logic        I_SECTOR_ERASED,
   output var  logic        O_CMD_VALID,
   output var  logic [7:0]  O_CMD_OPCODE,
   output var  logic [31:0] O_CMD_ADDR,
   output logic             O_BUSY,
   output logic             O_PROG_HALTED,
   output logic             O_ERASE_HALTED
);
   import erase_suspend_pkg::*;

   // ==========================================================
   // pin synchronisers and edge detection
   logic [2:0]  sck_sync;
   logic [2:0]  cs_sync;
   logic [3:0]  io_meta;
   logic [3:0]  io_s;
   logic        sck_rise;
   logic        cs_rise;

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         sck_sync <= 3'h0;
         cs_sync  <= 3'h7;
         io_meta  <= 4'h0;
         io_s     <= 4'h0;
      end else begin
         sck_sync <= {sck_sync[1:0], I_SPI_SCK};
         cs_sync  <= {cs_sync[1:0], I_SPI_CS_N};
         io_meta  <= I_SPI_IO;
         io_s     <= io_meta;
      end
   end

   assign sck_rise = sck_sync[1] & ~sck_sync[2];
   assign cs_rise  = cs_sync[1] & ~cs_sync[2];

   // ==========================================================
   // control register
   logic [2:0] ctrl;
   logic       quad;
   logic       addr4;
   logic       clr30;
   assign quad  = ctrl[CTRL_QUAD_BIT];
   assign addr4 = ctrl[CTRL_ADDR4_BIT];
   assign clr30 = ctrl[CTRL_CLR30_BIT];

   // ==========================================================
   // address bytes that follow each opcode
   function automatic logic [2:0] addr_len(input logic [7:0] opc, input logic wide);
      logic [2:0] n;
      n = 3'd0;
      case (opc)
         OPC_PAGE_PROG_WIDE, OPC_FETCH_WIDE, OPC_FAST_FETCH_WIDE, OPC_DUAL_FETCH_WIDE,
         OPC_QUAD_FETCH_WIDE, OPC_QUAD_DDR_FETCH, OPC_SECTOR_ERASE_W, OPC_SMALL_ERASE_W,
         OPC_LOCK_READ_W, OPC_LOCK_WRITE_W, OPC_PERSIST_READ_W: n = 3'd4;
         OPC_ERASE_CHECK, OPC_PAGE_PROG, OPC_FETCH, OPC_FAST_FETCH, OPC_DUAL_FETCH,
         OPC_QUAD_FETCH, OPC_SECTOR_ERASE, OPC_SMALL_ERASE, OPC_LOCK_READ,
         OPC_LOCK_WRITE, OPC_PERSIST_READ: n = wide ? 3'd4 : 3'd3;
         default: n = 3'd0;
      endcase
      return n;
   endfunction

   // commands permitted while an operation is suspended
   function automatic logic permitted(input logic [7:0] opc, input logic ph, input logic eh,
                                      input logic opt);
      logic r;
      r = 1'b0;
      case (opc)
         OPC_FETCH, OPC_FETCH_WIDE, OPC_FAST_FETCH, OPC_FAST_FETCH_WIDE, OPC_DUAL_FETCH,
         OPC_DUAL_FETCH_WIDE, OPC_QUAD_FETCH, OPC_QUAD_FETCH_WIDE, OPC_QUAD_DDR_FETCH: r = 1'b1;
         OPC_STATUS1_FETCH, OPC_ANY_REG_FETCH, OPC_STATUS2_FETCH: r = 1'b1;
         OPC_CONTINUE_A, OPC_CONTINUE_B: r = 1'b1;
         OPC_RESET_ARM, OPC_RESET: r = 1'b1;
         OPC_CLEAR_OPT: r = opt ? eh : 1'b1;
         OPC_CLEAR: r = eh;
         OPC_WRITE_PERMIT, OPC_PAGE_PROG, OPC_PAGE_PROG_WIDE: r = eh & ~ph;
         OPC_LOCK_READ, OPC_LOCK_WRITE, OPC_LOCK_READ_W, OPC_LOCK_WRITE_W,
         OPC_PERSIST_READ, OPC_PERSIST_READ_W: r = eh;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // ==========================================================
   // serial command receiver
   logic [7:0]  shreg;
   logic [3:0]  bit_cnt;
   logic [2:0]  byte_cnt;
   logic [7:0]  opcode;
   logic [31:0] addr;
   logic [7:0]  next_byte;
   logic [3:0]  next_bit_cnt;
   logic [2:0]  nbytes;

   assign next_byte    = quad ? {shreg[3:0], io_s} : {shreg[6:0], io_s[0]};
   assign next_bit_cnt = bit_cnt + (quad ? 4'd4 : 4'd1);
   assign nbytes       = addr_len(opcode, addr4);

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         shreg    <= 8'h00;
         bit_cnt  <= 4'h0;
         byte_cnt <= 3'h0;
         opcode   <= 8'h00;
         addr     <= 32'h0000_0000;
      end else if (cs_sync[2]) begin
         shreg    <= 8'h00;
         bit_cnt  <= 4'h0;
         byte_cnt <= 3'h0;
         addr     <= 32'h0000_0000;
      end else if (sck_rise && !cs_sync[1]) begin
         shreg <= next_byte;
         if (next_bit_cnt == 4'd8) begin
            bit_cnt <= 4'h0;
            if (byte_cnt != 3'd7) begin
               byte_cnt <= byte_cnt + 3'd1;
            end
            if (byte_cnt == 3'd0) begin
               opcode <= next_byte;
            end else if (byte_cnt <= nbytes) begin
               addr <= {addr[23:0], next_byte};
            end
         end else begin
            bit_cnt <= next_bit_cnt;
         end
      end
   end

   // ==========================================================
   // frame decode
   op_state_t   op_state;
   logic [CNT_W-1:0] timer;
   logic        prog_halted;
   logic        erase_halted;
   logic        halting_prog;
   logic        write_permit_latch;
   logic        p_err;
   logic        erase_ok;
   logic [31:0] erase_addr;
   logic        halted;
   logic        frame_ok;
   logic        accept;
   logic        idle;
   logic        is_halt;
   logic        is_cont;
   logic        is_prog;
   logic        is_erase;
   logic        is_clear;
   logic        same_sector;
   logic        take_check;
   logic        take_prog;
   logic        prog_fail;
   logic        take_erase;
   logic        take_bulk;
   logic        take_halt;
   logic        take_cont;

   assign halted   = prog_halted | erase_halted;
   assign idle     = (op_state == OP_IDLE);
   assign frame_ok = cs_rise && (bit_cnt == 4'h0) && ({1'b0, byte_cnt} >= {1'b0, nbytes} + 4'd1);
   assign accept   = frame_ok && (!halted || permitted(opcode, prog_halted, erase_halted, clr30));
   assign is_halt  = (opcode == OPC_HALT_A) || (opcode == OPC_HALT_B) || (opcode == OPC_HALT_C);
   assign is_cont  = (opcode == OPC_CONTINUE_A) || (opcode == OPC_CONTINUE_B) ||
                     ((opcode == OPC_CLEAR_OPT) && !clr30);
   assign is_prog  = (opcode == OPC_PAGE_PROG) || (opcode == OPC_PAGE_PROG_WIDE);
   assign is_erase = (opcode == OPC_SECTOR_ERASE) || (opcode == OPC_SECTOR_ERASE_W) ||
                     (opcode == OPC_SMALL_ERASE) || (opcode == OPC_SMALL_ERASE_W);
   assign is_clear = (opcode == OPC_CLEAR) || ((opcode == OPC_CLEAR_OPT) && clr30);
   assign same_sector = erase_halted && (addr[31:SECTOR_W] == erase_addr[31:SECTOR_W]);

   assign take_check = accept && idle && (opcode == OPC_ERASE_CHECK);
   assign take_prog  = accept && idle && is_prog && write_permit_latch && !same_sector && !prog_halted;
   assign prog_fail  = accept && idle && is_prog && write_permit_latch && same_sector && !prog_halted;
   assign take_erase = accept && idle && is_erase && write_permit_latch && !halted;
   assign take_bulk  = accept && idle && write_permit_latch && !halted &&
                       ((opcode == OPC_BULK_ERASE) || (opcode == OPC_BULK_ERASE_ALT));
   assign take_halt  = accept && is_halt && ((op_state == OP_PROGRAM) || (op_state == OP_SECTOR));
   assign take_cont  = accept && idle && is_cont && halted;

   // ==========================================================
   // operation sequencer
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         op_state     <= OP_IDLE;
         timer        <= '0;
         halting_prog <= 1'b0;
      end else begin
         if (timer != '0) begin
            timer <= timer - 1'b1;
         end
         case (op_state)
            OP_IDLE: begin
               if (take_check) begin
                  op_state <= OP_CHECK;
                  timer    <= CNT_W'(CHECK_CYC);
               end else if (take_prog) begin
                  op_state <= OP_PROGRAM;
                  timer    <= CNT_W'(OP_CYC);
               end else if (take_erase) begin
                  op_state <= OP_SECTOR;
                  timer    <= CNT_W'(OP_CYC);
               end else if (take_bulk) begin
                  op_state <= OP_BULK;
                  timer    <= CNT_W'(OP_CYC);
               end else if (take_cont) begin
                  op_state <= prog_halted ? OP_PROGRAM : OP_SECTOR;
                  timer    <= CNT_W'(OP_CYC);
               end
            end
            OP_PROGRAM, OP_SECTOR: begin
               if (take_halt) begin
                  op_state     <= OP_HALTING;
                  timer        <= CNT_W'(HALT_CYC);
                  halting_prog <= (op_state == OP_PROGRAM);
               end else if (timer == '0) begin
                  op_state <= OP_IDLE;
               end
            end
            OP_BULK, OP_CHECK, OP_HALTING: begin
               if (timer == '0) begin
                  op_state <= OP_IDLE;
               end
            end
            default: op_state <= OP_IDLE;
         endcase
      end
   end

   // ==========================================================
   // suspend status bits
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         prog_halted  <= 1'b0;
         erase_halted <= 1'b0;
      end else begin
         if (op_state == OP_HALTING && timer == '0) begin
            if (halting_prog) begin
               prog_halted <= 1'b1;
            end else begin
               erase_halted <= 1'b1;
            end
         end else if (take_cont) begin
            if (prog_halted) begin
               prog_halted <= 1'b0;
            end else begin
               erase_halted <= 1'b0;
            end
         end
      end
   end

   // write permit latch, program error, erase result, erased sector
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         write_permit_latch        <= 1'b0;
         p_err      <= 1'b0;
         erase_ok   <= 1'b0;
         erase_addr <= 32'h0000_0000;
      end else begin
         if (take_check) begin
            write_permit_latch <= 1'b1;
         end else if (accept && idle && opcode == OPC_WRITE_PERMIT) begin
            write_permit_latch <= 1'b1;
         end else if ((op_state == OP_CHECK && timer == '0) || take_prog || prog_fail ||
                      take_erase || take_bulk || (accept && idle && is_clear)) begin
            write_permit_latch <= 1'b0;
         end
         if (prog_fail) begin
            p_err <= 1'b1;
         end else if (accept && idle && is_clear) begin
            p_err <= 1'b0;
         end
         if (op_state == OP_CHECK && timer == '0) begin
            erase_ok <= I_SECTOR_ERASED;
         end
         if (take_erase) begin
            erase_addr <= addr;
         end
      end
   end

   // accepted command reported to the array side
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_CMD_VALID  <= 1'b0;
         O_CMD_OPCODE <= 8'h00;
         O_CMD_ADDR   <= 32'h0000_0000;
      end else begin
         O_CMD_VALID <= accept;
         if (accept) begin
            O_CMD_OPCODE <= opcode;
            O_CMD_ADDR   <= addr;
         end
      end
   end

   assign O_BUSY         = !idle;
   assign O_PROG_HALTED  = prog_halted;
   assign O_ERASE_HALTED = erase_halted;

   // ==========================================================
   // register bus slave, one wait cycle per access
   logic        ack;
   logic [31:0] status_word;
   assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack;
   assign status_word = {16'h0000,
                         5'h00, erase_ok, erase_halted, prog_halted,
                         1'b0, p_err, 4'h0, write_permit_latch, !idle};

   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ack            <= 1'b0;
         ctrl           <= CTRL_RESET;
         O_AVS_READDATA <= 32'h0000_0000;
      end else begin
         ack <= (I_AVS_READ | I_AVS_WRITE) & ~ack;
         if (I_AVS_READ && !ack) begin
            if (I_AVS_ADDRESS == REG_CTRL) begin
               O_AVS_READDATA <= {29'h0, ctrl};
            end else if (I_AVS_ADDRESS == REG_STATUS) begin
               O_AVS_READDATA <= status_word;
            end else if (I_AVS_ADDRESS == REG_LAST_CMD) begin
               O_AVS_READDATA <= {24'h000000, O_CMD_OPCODE};
            end else if (I_AVS_ADDRESS == REG_ERASE_SECTOR) begin
               O_AVS_READDATA <= erase_addr;
            end else begin
               O_AVS_READDATA <= 32'h0000_0000;
            end
         end
         if (I_AVS_WRITE && ack && I_AVS_ADDRESS == REG_CTRL && I_AVS_BYTEENABLE[0]) begin
            ctrl <= I_AVS_WRITEDATA[2:0];
         end
      end
   end

   // ==========================================================
   // checks
   sequence check_start_s;
      take_check;
   endsequence
   sequence check_end_s;
      op_state == OP_CHECK && timer == '0;
   endsequence

   // suspend latency is far beyond a delay range, so it is counted here
   logic [CNT_W-1:0] halt_span;
   always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         halt_span <= '0;
      end else if (op_state == OP_HALTING) begin
         halt_span <= halt_span + 1'b1;
      end else begin
         halt_span <= '0;
      end
   end

   check_busy_a : assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      check_start_s |=> (O_BUSY && write_permit_latch) [*8])
      else $error("busy or permit latch dropped during erase check");
   check_result_a : assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      check_end_s |=> (erase_ok == $past(I_SECTOR_ERASED)) && !write_permit_latch && !O_BUSY)
      else $error("erase check result or end state wrong");
   halt_latency_a : assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (op_state == OP_HALTING) |-> O_BUSY && (halt_span <= CNT_W'(HALT_CYC)))
      else $error("suspend did not complete in time");
   halt_done_a : assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (op_state == OP_HALTING && timer == '0) |=> !O_BUSY && (prog_halted || erase_halted))
      else $error("suspend ended without a halted bit");
   bulk_nohalt_a : assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (op_state == OP_BULK && frame_ok && is_halt) |=> op_state != OP_HALTING)
      else $error("bulk erase was suspended");
   erase_ignored_a : assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (idle && halted && frame_ok && is_erase) |=> idle)
      else $error("erase started while suspended");
   prog_blocked_a : assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (idle && prog_halted && frame_ok && is_prog) |=> idle && !O_CMD_VALID)
      else $error("program accepted with program suspended");
   prog_err_a : assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      prog_fail |=> p_err && idle && !write_permit_latch)
      else $error("program into halted sector did not fail");
   permit_filter_a : assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (prog_halted && frame_ok && opcode == OPC_WRITE_PERMIT) |=> !O_CMD_VALID && $stable(write_permit_latch))
      else $error("write permit accepted during program suspend");
   reset_any_a : assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
      (frame_ok && opcode == OPC_RESET) |=> O_CMD_VALID && O_CMD_OPCODE == OPC_RESET)
      else $error("reset command not accepted");
endmodule
`default_nettype wire

// ==== spi_host_model.sv ====
// serial host model that frames flash commands
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input  wire logic       i_clk,
   output var  logic       o_sck,
   output var  logic       o_cs_n,
   output var  logic [3:0] o_io
);
   initial begin
      o_sck  = 1'b0;
      o_cs_n = 1'b1;
      o_io   = 4'hA;
   end
   // ==========================================================
   // frame: opcode then address bytes, msb first; quad moves a nibble a clock
   task automatic frame(input logic [39:0] data, input int nbytes, input logic quad);
      logic [39:0] sr;
      sr = data;
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      for (int i = 0; i < (quad ? 2 * nbytes : 8 * nbytes); i++) begin
         @(posedge i_clk);
         o_io <= quad ? sr[39:36] : {~o_io[3:1], sr[39]};
         sr = quad ? sr << 4 : sr << 1;
         repeat (4) @(posedge i_clk);
         o_sck <= 1'b1;
         repeat (4) @(posedge i_clk);
         o_sck <= 1'b0;
      end
      repeat (4) @(posedge i_clk);
      o_cs_n <= 1'b1;
      // released lines show the inverse, not the last bit
      o_io   <= ~o_io;
      repeat (6) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// ==== erase_suspend_ctrl_tb_top.sv ====
// self-checking bench for the erase-check and suspend controller
`timescale 1ns/1ps
`default_nettype none
module erase_suspend_ctrl_tb_top;
   import erase_suspend_pkg::*;
   logic        clk, nrst, rd, wr, erased, wreq, cvld, busy, sck, cs_n;
   logic [3:0]  aa, io;
   logic [2:0]  mode;
   logic [7:0]  cop, halt [3];
   logic [31:0] wd, rdata, rdd, cad, ad;
   logic [7:0]  exp_q [$];
   int          n_mismatch, check_count;
   erase_suspend_ctrl #(.CHECK_CYC(40), .HALT_CYC(20), .OP_CYC(600)) dut (.I_SYS_CLK(clk), .I_NRST(nrst),
      .I_AVS_ADDRESS(aa), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hF),
      .O_AVS_READDATA(rdd), .O_AVS_WAITREQUEST(wreq), .I_SPI_SCK(sck), .I_SPI_CS_N(cs_n), .I_SPI_IO(io),
      .I_SECTOR_ERASED(erased), .O_CMD_VALID(cvld), .O_CMD_OPCODE(cop), .O_CMD_ADDR(cad), .O_BUSY(busy),
      .O_PROG_HALTED(), .O_ERASE_HALTED());
   spi_host_model host (.i_clk(clk), .o_sck(sck), .o_cs_n(cs_n), .o_io(io));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      aa <= a;
      wd <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      rdata = rdd;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic st_chk(input logic [31:0] m, input logic [31:0] e);
      av(1'b0, REG_STATUS, 32'h0);
      chk(rdata & m, e);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 400; i++) begin
         av(1'b0, REG_STATUS, 32'h0);
         if (rdata[ST1_BUSY_BIT] === 1'b0) break;
      end
   endtask
   task automatic cmd(input logic [7:0] op, input logic acc, input logic has_a);
      logic w;
      w = mode[1] || op == OPC_FETCH_WIDE || op == OPC_PAGE_PROG_WIDE;
      if (acc) exp_q.push_back(op);
      host.frame(w ? {op, ad} : {op, ad[23:0], 8'h00}, has_a ? (w ? 5 : 4) : 1, mode[0]);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ==========================================================
   // monitor: each accepted frame is matched to the oldest expected opcode
   always @(posedge clk) begin
      if (cvld === 1'b1) begin
         chk({24'h0, cop}, {24'h0, exp_q.size() ? exp_q[0] : 8'hFF});
         if (exp_q.size()) void'(exp_q.pop_front());
      end
   end
   initial begin
      #1_000_000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      {nrst, rd, wr, erased, aa, wd, mode, n_mismatch, check_count} = '0;
      halt = '{OPC_HALT_A, OPC_HALT_B, OPC_HALT_C};
      ad = $urandom(19901);
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      for (int m = 0; m < 4; m += 3) begin
         mode = m[2:0];
         av(1'b1, REG_CTRL, {29'h0, mode});
         erased <= 1'($urandom_range(1, 0));
         ad = $urandom();
         cmd(OPC_ERASE_CHECK, 1'b1, 1'b1);
         st_chk(32'h3, 32'h3);
         wait_idle();
         st_chk(32'h403, {21'h0, erased, 10'h0});
      end
      mode = 3'h0;
      av(1'b1, REG_CTRL, 32'h0);
      av(1'b0, 4'h2, 32'h0);
      chk(rdata, 32'h0);
      $display("test erase_check done");
      foreach (halt[k]) begin
         cmd(OPC_WRITE_PERMIT, 1'b1, 1'b0);
         cmd(OPC_PAGE_PROG, 1'b1, 1'b1);
         cmd(halt[k], 1'b1, 1'b0);
         wait_idle();
         st_chk(32'h301, 32'h100);
         cmd(OPC_WRITE_PERMIT, 1'b0, 1'b0);
         cmd(OPC_LOCK_WRITE, 1'b0, 1'b1);
         cmd(OPC_FETCH_WIDE, 1'b1, 1'b1);
         cmd(OPC_ANY_REG_FETCH, 1'b1, 1'b0);
         cmd(OPC_CONTINUE_A, 1'b1, 1'b0);
         wait_idle();
         st_chk(32'h301, 32'h0);
      end
      $display("test program_suspend done");
      cmd(OPC_WRITE_PERMIT, 1'b1, 1'b0);
      cmd(OPC_SECTOR_ERASE, 1'b1, 1'b1);
      cmd(OPC_HALT_C, 1'b1, 1'b0);
      wait_idle();
      st_chk(32'h301, 32'h200);
      cmd(OPC_SECTOR_ERASE, 1'b0, 1'b1);
      cmd(OPC_LOCK_READ, 1'b1, 1'b1);
      cmd(OPC_STATUS2_FETCH, 1'b1, 1'b0);
      cmd(OPC_WRITE_PERMIT, 1'b1, 1'b0);
      cmd(OPC_PAGE_PROG, 1'b1, 1'b1);
      st_chk(32'h41, 32'h40);
      cmd(OPC_CLEAR, 1'b1, 1'b0);
      st_chk(32'h40, 32'h0);
      cmd(OPC_CONTINUE_B, 1'b1, 1'b0);
      wait_idle();
      st_chk(32'h301, 32'h0);
      $display("test erase_suspend done");
      cmd(OPC_WRITE_PERMIT, 1'b1, 1'b0);
      cmd(OPC_BULK_ERASE, 1'b1, 1'b0);
      cmd(OPC_HALT_B, 1'b1, 1'b0);
      repeat (40) @(posedge clk);
      st_chk(32'h301, 32'h1);
      wait_idle();
      $display("test bulk_no_suspend done");
      wrap_up();
   end
endmodule
`default_nettype wire
